// ---- bench/external_data_move_stretch_cycle_timing_sva.sv ----
`timescale 1ns/1ps
`default_nettype none

module external_data_move_stretch_sva (
  input wire logic                           core_clk_i,
  input wire logic                           rst_n_i,
  input wire logic                           instr_valid_i,
  input wire logic                           instr_take_o,
  input wire logic                           opcode_fetch_o,
  input wire external_data_move_stretch_pkg::cycle_state_t cycle_state_o,
  input wire logic                           clock_control_wr_i,
  input wire logic [7:0]                     clock_control_wdata_i,
  input wire logic [7:0]                     clock_control_reg_o,
  input wire external_data_move_stretch_pkg::xbus_t        xbus_o,
  input wire logic [7:0]                     xdata_i,
  input wire logic [7:0]                     xread_data_o,
  input wire logic                           xread_valid_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [4:0] cnt;
  logic [2:0] s;
  wire logic  stb = xbus_o.read_strobe | xbus_o.write_strobe;
  // Stretch as it stood at the take edge, the one the core uses
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= 5'h00;
      s   <= 3'h0;
    end else begin
      cnt <= stb ? cnt + 5'h01 : 5'h00;
      if (instr_take_o) s <= $past(clock_control_reg_o[2:0]);
    end
  end
  step_a: assert property (
    $past(rst_n_i)
    |-> cycle_state_o == 2'($past(cycle_state_o) + 2'h1))
    else $error("state order broken");
  fetch_slot_a: assert property (
    opcode_fetch_o |-> cycle_state_o == external_data_move_stretch_pkg::STATE_ONE)
    else $error("fetch outside first state");
  fetch_once_a: assert property (
    opcode_fetch_o |=> !opcode_fetch_o [*3])
    else $error("second fetch in one cycle");
  take_edge_a: assert property (
    instr_take_o |-> opcode_fetch_o && $past(instr_valid_i)
    && $past(cycle_state_o) == external_data_move_stretch_pkg::STATE_FOUR)
    else $error("take without fetch or off boundary");
  reg_write_a: assert property (
    clock_control_wr_i
    |=> clock_control_reg_o == $past(clock_control_wdata_i))
    else $error("register write lost");
  reg_keep_a: assert property (
    !clock_control_wr_i |=> $stable(clock_control_reg_o))
    else $error("register changed unwritten");
  strobe_len_a: assert property (
    $fell(stb) |-> cnt == (s == 3'h0 ? 5'h02 : {s, 2'b00}))
    else $error("strobe width wrong");
  read_take_a: assert property (
    $fell(xbus_o.read_strobe)
    |-> xread_valid_o && xread_data_o == $past(xdata_i))
    else $error("read data not captured");
  write_drive_a: assert property (
    stb |-> xbus_o.data_oe == xbus_o.write_strobe)
    else $error("data drive does not follow access direction");
  cover property (instr_take_o);
  cover property ($fell(xbus_o.read_strobe));
  cover property ($fell(xbus_o.write_strobe) && s == 3'h7);
endmodule : external_data_move_stretch_sva

bind external_data_move_stretch_cycle_timing external_data_move_stretch_sva external_data_move_stretch_sva_inst (
  .core_clk_i, .rst_n_i, .instr_valid_i, .instr_take_o, .opcode_fetch_o,
  .cycle_state_o, .clock_control_wr_i, .clock_control_wdata_i,
  .clock_control_reg_o, .xbus_o, .xdata_i, .xread_data_o, .xread_valid_o);

`default_nettype wire

// ---- bench/tb_external_data_move_stretch_cycle_timing.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_external_data_move_stretch_cycle_timing;
  logic                           core_clk_i, rst_n_i, instr_valid_i;
  logic                           instr_take_o, instr_done_o;
  logic                           opcode_fetch_o, clock_control_wr_i;
  logic                           xread_valid_o;
  external_data_move_stretch_pkg::instr_desc_t  instr_i;
  external_data_move_stretch_pkg::cycle_state_t cycle_state_o;
  external_data_move_stretch_pkg::xbus_t        xbus_o;
  logic [7:0]                     clock_control_wdata_i;
  logic [7:0]                     clock_control_reg_o;
  logic [7:0]                     xdata_i, xread_data_o, rd;
  logic [1:0]                     lat;
  int                             mismatches = 0;
  int                             n_compared = 0;

  external_data_move_stretch_cycle_timing external_data_move_stretch_cycle_timing_inst (
    .core_clk_i, .rst_n_i, .instr_valid_i, .instr_i, .instr_take_o,
    .instr_done_o, .opcode_fetch_o, .cycle_state_o, .clock_control_wr_i,
    .clock_control_wdata_i, .clock_control_reg_o, .xbus_o, .xdata_i,
    .xread_data_o, .xread_valid_o);
  xmem_model xmem_model_inst (
    .core_clk_i, .xbus_i(xbus_o), .lat_i(lat), .xdata_o(xdata_i));

  always #50 core_clk_i = ~core_clk_i;

  task tick();
    @(posedge core_clk_i);
    #1;
  endtask : tick

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task end_sim();
    $display("compared=%0d mismatches=%0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim

  // Offer one instruction, then count clocks from take to done
  task automatic run(input int b, input int br, input int xm,
                     input int xw, input logic [7:0] a, input int nc);
    int k;
    int nf;
    int ef;
    instr_i = '{bytes: b[2:0], branch: br[0], xmove: xm[0], xwrite: xw[0],
                addr: {8'h12, a}, wdata: a ^ 8'h5A};
    instr_valid_i = 1'b1;
    rd = 8'h00;
    k = 0;
    // Fetches: one for a move, else the byte count clamped to 1..4
    ef = (xm != 0) ? 1 : (b < 1) ? 1 : (b > 4) ? 4 : b;
    while (instr_take_o !== 1'b1 && k < 50) begin
      tick();
      k++;
    end
    chk(instr_take_o, 1'b1);
    nf = (opcode_fetch_o === 1'b1) ? 1 : 0;
    instr_valid_i = 1'b0;
    k = 0;
    do begin
      tick();
      k++;
      if (opcode_fetch_o === 1'b1) nf++;
      if (xread_valid_o === 1'b1) rd = xread_data_o;
    end while (instr_done_o !== 1'b1 && k < 200);
    chk(k, 4 * nc);
    chk(nf, ef);
    // Pins still show the move here: data drive drops half a clock later
    if (xm != 0) begin
      chk(xbus_o.addr, {8'h12, a});
      chk(xbus_o.data_oe, xw[0]);
    end
  endtask : run

  task setreg(input logic [7:0] v);
    clock_control_wr_i = 1'b1;
    clock_control_wdata_i = v;
    tick();
    clock_control_wr_i = 1'b0;
    tick();
    chk(clock_control_reg_o, v);
  endtask : setreg

  task t_reset();
    chk(clock_control_reg_o, 8'h01);
    chk(cycle_state_o, external_data_move_stretch_pkg::STATE_ONE);
    rst_n_i = 1'b1;
    run(1, 0, 1, 1, 8'h40, 3);
  endtask : t_reset

  // Maximum stretch must leave ordinary instructions untouched
  task t_normal();
    setreg(8'h07);
    for (int b = 1; b < 5; b++)
      for (int br = 0; br < 2; br++)
        run(b, br, 0, 0, 8'h00, b + br);
    run(0, 0, 0, 0, 8'h00, 1);
    run(7, 1, 0, 0, 8'h00, 5);
  endtask : t_normal

  // Upper register bits set to show only the low three count
  task t_moves();
    for (int s = 0; s < 8; s++) begin
      setreg(8'hF8 | 8'(s));
      lat = 2'(s == 0 ? 1 : s);
      run(1, 0, 1, 1, 8'(s), 2 + s);
      run(1, 0, 1, 0, 8'(s), 2 + s);
      chk(rd, 8'(s) ^ 8'h5A);
    end
  endtask : t_moves

  // A second reset must restore the default stretch of one
  task t_rerun();
    rst_n_i = 1'b0;
    tick();
    tick();
    chk(clock_control_reg_o, 8'h01);
    rst_n_i = 1'b1;
    run(1, 0, 1, 0, 8'h40, 3);
    chk(rd, 8'h40 ^ 8'h5A);
  endtask : t_rerun

  initial begin
    core_clk_i = 1'b0;
    rst_n_i = 1'b0;
    instr_valid_i = 1'b0;
    instr_i = '0;
    clock_control_wr_i = 1'b0;
    clock_control_wdata_i = 8'h00;
    lat = 2'h0;
    rd = 8'h00;
    repeat (6) @(posedge core_clk_i);
    #1;
    t_reset();
    t_normal();
    t_moves();
    t_rerun();
    end_sim();
  end

  // Whole run needs about 620 clocks; 20000, over thirty times that, means a hang
  initial begin
    #2000000;
    mismatches++;
    end_sim();
  end
endmodule : tb_external_data_move_stretch_cycle_timing

`default_nettype wire

// ---- bench/xmem_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module xmem_model (
  input  wire logic                    core_clk_i,
  input  wire external_data_move_stretch_pkg::xbus_t xbus_i,
  input  wire logic [1:0]              lat_i,
  output var  logic [7:0]              xdata_o
);
  logic [7:0] mem [256];
  logic [7:0] last = 8'h00;
  logic       ok;
  int         n = 0;
  // A slow part settles only after lat_i clocks; before that, junk
  assign ok = xbus_i.read_strobe && n >= lat_i;
  assign xdata_o = ok ? mem[xbus_i.addr[7:0]] : ~last;
  always @(posedge core_clk_i) begin
    n <= xbus_i.read_strobe ? n + 1 : 0;
    if (ok) last <= xdata_o;
    if (xbus_i.write_strobe) mem[xbus_i.addr[7:0]] <= xbus_i.data;
  end
endmodule : xmem_model

`default_nettype wire

// ---- verilog/external_data_move_stretch_cfg.svh ----
`ifndef EXTERNAL_DATA_MOVE_STRETCH_CFG_SVH
`define EXTERNAL_DATA_MOVE_STRETCH_CFG_SVH

// Machine cycle shape
`define STATES_PER_CYCLE     3'h4
`define MAX_INSTR_CYCLES     4'h5
`define MIN_INSTR_CYCLES     4'h1
`define MAX_INSTR_BYTES      3'h4

// Clock control register layout and reset value
`define CLOCK_CONTROL_RESET  8'h01
`define STRETCH_LSB          0
`define STRETCH_MSB          2

// External data move timing
`define XMOVE_BASE_CYCLES    4'h2
`define STROBE_FAST_CLOCKS   5'h02
`define STROBE_UNIT_CLOCKS   5'h04
`define STROBE_FAST_START    5'h01
`define STROBE_SLOW_START    5'h02

`endif

// ---- verilog/external_data_move_stretch_cycle_timing.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "external_data_move_stretch_cfg.svh"

module external_data_move_stretch_cycle_timing (
  input  wire logic                           core_clk_i,
  input  wire logic                           rst_n_i,
  input  wire logic                           instr_valid_i,
  input  wire external_data_move_stretch_pkg::instr_desc_t  instr_i,
  output var  logic                           instr_take_o,
  output var  logic                           instr_done_o,
  output var  logic                           opcode_fetch_o,
  output var  external_data_move_stretch_pkg::cycle_state_t cycle_state_o,
  input  wire logic                           clock_control_wr_i,
  input  wire logic [7:0]                     clock_control_wdata_i,
  output var  logic [7:0]                     clock_control_reg_o,
  output var  external_data_move_stretch_pkg::xbus_t        xbus_o,
  input  wire logic [7:0]                     xdata_i,
  output var  logic [7:0]                     xread_data_o,
  output var  logic                           xread_valid_o
);

  external_data_move_stretch_pkg::core_state_t s;
  external_data_move_stretch_pkg::core_state_t next_s;

  function automatic logic [1:0] phase_index(
    input external_data_move_stretch_pkg::cycle_state_t ph
  );
    logic [1:0] r;
    r = 2'h0;
    case (ph)
      external_data_move_stretch_pkg::STATE_ONE:   r = 2'h0;
      external_data_move_stretch_pkg::STATE_TWO:   r = 2'h1;
      external_data_move_stretch_pkg::STATE_THREE: r = 2'h2;
      external_data_move_stretch_pkg::STATE_FOUR:  r = 2'h3;
      default:                       r = 2'h0;
    endcase
    return r;
  endfunction : phase_index

  logic        last_state;
  logic        finishing;
  logic [3:0]  last_idx;
  logic [2:0]  stretch;
  logic [3:0]  byte_cycles;
  logic [3:0]  norm_total;
  logic [2:0]  norm_bytes;
  logic        in_access;
  logic [4:0]  acc_clk;
  logic [5:0]  strobe_end;
  logic        strobe_on;

  always_comb begin
    next_s = s;
    next_s.take = 1'b0;
    next_s.done = 1'b0;
    next_s.fetch = 1'b0;
    next_s.rvalid = 1'b0;
    stretch = s.clock_control[`STRETCH_MSB:`STRETCH_LSB];
    last_state = (s.phase == external_data_move_stretch_pkg::STATE_FOUR);
    last_idx = 4'(s.total - 4'h1);
    finishing = !s.busy || (s.idx == last_idx);

    // Software view of the clock control register
    if (clock_control_wr_i) begin
      next_s.clock_control = clock_control_wdata_i;
    end

    // Four states per machine cycle, fixed order
    case (s.phase)
      external_data_move_stretch_pkg::STATE_ONE: begin
        next_s.phase = external_data_move_stretch_pkg::STATE_TWO;
      end
      external_data_move_stretch_pkg::STATE_TWO: begin
        next_s.phase = external_data_move_stretch_pkg::STATE_THREE;
      end
      external_data_move_stretch_pkg::STATE_THREE: begin
        next_s.phase = external_data_move_stretch_pkg::STATE_FOUR;
      end
      external_data_move_stretch_pkg::STATE_FOUR: begin
        next_s.phase = external_data_move_stretch_pkg::STATE_ONE;
      end
      default: begin
        next_s.phase = external_data_move_stretch_pkg::STATE_ONE;
      end
    endcase

    // Normal instruction length: one cycle per byte, plus one for branches
    norm_bytes = instr_i.bytes;
    if (norm_bytes == 3'h0) begin
      norm_bytes = 3'h1;
    end else if (norm_bytes > `MAX_INSTR_BYTES) begin
      norm_bytes = `MAX_INSTR_BYTES;
    end
    byte_cycles = {1'b0, norm_bytes};
    norm_total = 4'(byte_cycles + {3'h0, instr_i.branch});
    if (norm_total > `MAX_INSTR_CYCLES) begin
      norm_total = `MAX_INSTR_CYCLES;
    end else if (norm_total < `MIN_INSTR_CYCLES) begin
      norm_total = `MIN_INSTR_CYCLES;
    end

    // Instruction boundaries fall only on state_four to state_one
    if (last_state) begin
      if (!finishing) begin
        next_s.idx = 4'(s.idx + 4'h1);
      end else begin
        next_s.done = s.busy;
        next_s.busy = 1'b0;
        next_s.idx = 4'h0;
        next_s.xmove = 1'b0;
        if (instr_valid_i) begin
          next_s.take = 1'b1;
          next_s.busy = 1'b1;
          next_s.xmove = instr_i.xmove;
          next_s.xwrite = instr_i.xwrite;
          next_s.addr = instr_i.addr;
          next_s.wdata = instr_i.wdata;
          if (instr_i.xmove) begin
            // Stretch sampled once per move; the CPU simply stays here
            next_s.total = 4'(`XMOVE_BASE_CYCLES + {1'b0, stretch});
            next_s.fetches = 3'h1;
            if (stretch == 3'h0) begin
              next_s.strobe_start = `STROBE_FAST_START;
              next_s.strobe_len = `STROBE_FAST_CLOCKS;
            end else begin
              next_s.strobe_start = `STROBE_SLOW_START;
              next_s.strobe_len = 5'(`STROBE_UNIT_CLOCKS * {2'h0, stretch});
            end
          end else begin
            next_s.total = norm_total;
            next_s.fetches = norm_bytes;
            next_s.strobe_start = 5'h00;
            next_s.strobe_len = 5'h00;
          end
        end
      end
      // One fetch per cycle, only in cycles that carry an opcode byte
      next_s.fetch = next_s.busy
                  && (next_s.idx < {1'b0, next_s.fetches});
    end

    // Access phase: every cycle of a move after its fetch cycle
    in_access = next_s.busy && next_s.xmove && (next_s.idx != 4'h0);
    acc_clk = 5'({4'(next_s.idx - 4'h1), 2'h0})
            | {3'h0, phase_index(next_s.phase)};
    strobe_end = {1'b0, next_s.strobe_start} + {1'b0, next_s.strobe_len};
    strobe_on = in_access
             && (acc_clk >= next_s.strobe_start)
             && ({1'b0, acc_clk} < strobe_end);

    if (in_access) begin
      next_s.bus.addr = next_s.addr;
    end
    next_s.bus.read_strobe = strobe_on && !next_s.xwrite;
    next_s.bus.write_strobe = strobe_on && next_s.xwrite;
    next_s.bus.data = next_s.wdata;
    next_s.bus.data_oe = in_access && next_s.xwrite;

    // Sample read data on the rising edge that ends the core strobe; the
    // pin strobe falls half a clock later, so data is held past the sample
    if (s.bus.read_strobe && !next_s.bus.read_strobe) begin
      next_s.rdata = xdata_i;
      next_s.rvalid = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
      s.phase <= external_data_move_stretch_pkg::STATE_ONE;
      s.total <= `MIN_INSTR_CYCLES;
      s.clock_control <= `CLOCK_CONTROL_RESET;
    end else begin
      s <= next_s;
    end
  end

  // Pins move on the falling edge, half a clock after the core
  half_edge_stage #(
    .WIDTH ($bits(external_data_move_stretch_pkg::xbus_t))
  ) u_pin_stage (
    .clk_i   (core_clk_i),
    .rst_n_i (rst_n_i),
    .d_i     (s.bus),
    .q_o     (xbus_o)
  );

  assign instr_take_o        = s.take;
  assign instr_done_o        = s.done;
  assign opcode_fetch_o      = s.fetch;
  assign cycle_state_o       = s.phase;
  assign clock_control_reg_o = s.clock_control;
  assign xread_data_o        = s.rdata;
  assign xread_valid_o       = s.rvalid;

endmodule : external_data_move_stretch_cycle_timing

`default_nettype wire

// ---- verilog/external_data_move_stretch_pkg.sv ----
`default_nettype none

package external_data_move_stretch_pkg;

  typedef enum logic [1:0] {
    STATE_ONE,
    STATE_TWO,
    STATE_THREE,
    STATE_FOUR
  } cycle_state_t;

  // One instruction as handed in by the sequencer above this block
  typedef struct packed {
    logic [2:0]  bytes;
    logic        branch;
    logic        xmove;
    logic        xwrite;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } instr_desc_t;

  // External data memory bus as launched toward the pins
  typedef struct packed {
    logic [15:0] addr;
    logic        read_strobe;
    logic        write_strobe;
    logic [7:0]  data;
    logic        data_oe;
  } xbus_t;

  typedef struct packed {
    cycle_state_t phase;
    logic         busy;
    logic [3:0]   idx;
    logic [3:0]   total;
    logic [2:0]   fetches;
    logic         xmove;
    logic         xwrite;
    logic [4:0]   strobe_start;
    logic [4:0]   strobe_len;
    logic [15:0]  addr;
    logic [7:0]   wdata;
    logic [7:0]   clock_control;
    logic         take;
    logic         done;
    logic         fetch;
    logic [7:0]   rdata;
    logic         rvalid;
    xbus_t        bus;
  } core_state_t;

endpackage : external_data_move_stretch_pkg

`default_nettype wire

// ---- verilog/half_edge_stage.sv ----
`timescale 1ns/1ps
`default_nettype none

module half_edge_stage #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] d_i,
  output var  logic [WIDTH-1:0] q_o
);

  typedef struct packed {
    logic [WIDTH-1:0] q;
  } stage_state_t;

  stage_state_t s;
  stage_state_t next_s;

  always_comb begin
    next_s.q = d_i;
  end

  // Falling-edge launch: moves the pins half a clock after the core decision
  always_ff @(negedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign q_o = s.q;

endmodule : half_edge_stage

`default_nettype wire
